// ### ltmc_pkg.sv
// Constants and shared types for the LIN transceiver mode control pair.
// Assumes one system clock of 250 MHz shared by both ends.
//
// Functional notes
// - Exactly four modes: power-on, sleep, standby, normal.
// - Low supply holds power-on; good supply enters sleep.
// - Enter normal after sleep control high long enough.
// - Sleep control low long enough leaves normal.
// - Remote wake needs falling, long low, rising bus.
// - Sleep mode filters remote wake-ups.
// - Remote wake enters standby, receive output driven low.
// - Sleep control high in standby clears wake request.
// - Sleep control high clears source and request flags.
// - Transmitter and receiver work only in normal mode.
// - Bus high is recessive, low is dominant.
// - Receive output floats in sleep and power-on.
// - Driver stays off until transmit input seen high; an arming left from a prior normal stay enables it on the first normal cycle.
// - Over-temperature disables the bus driver.
// - Undervoltage disables driver until supply is high.
// - Pass data both ways, at most 20 kBd.
package ltmc_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int LTMC_CLK_MHZ = 250;
  localparam int LTMC_CNT_W = 16;
  // Filter times in ns; plain defaults, the figures are not fixed anywhere.
  localparam int LTMC_T_GOTO_NORM_NS = 4000;
  localparam int LTMC_T_GOTO_SLEEP_NS = 4000;
  localparam int LTMC_T_WAKE_DOM_NS = 8000;
  // Least times, so the counts round up.
  localparam int LTMC_NORM_CYCLES = (LTMC_T_GOTO_NORM_NS * LTMC_CLK_MHZ + 999) / 1000;
  localparam int LTMC_SLEEP_CYCLES = (LTMC_T_GOTO_SLEEP_NS * LTMC_CLK_MHZ + 999) / 1000;
  localparam int LTMC_WAKE_CYCLES = (LTMC_T_WAKE_DOM_NS * LTMC_CLK_MHZ + 999) / 1000;
  // Highest bit rate and the least bit time it implies.
  localparam int LTMC_MAX_BAUD = 20000;
  localparam int LTMC_T_BIT_NS = 1000000000 / LTMC_MAX_BAUD;
  localparam int LTMC_BIT_CYCLES = (LTMC_T_BIT_NS / 1000) * LTMC_CLK_MHZ;
  // Host keeps each sleep control level this long, with room for the synchroniser.
  localparam int LTMC_HOLD_MARGIN = 8;
  localparam int LTMC_HOLD_CYCLES =
    ((LTMC_NORM_CYCLES > LTMC_SLEEP_CYCLES) ? LTMC_NORM_CYCLES : LTMC_SLEEP_CYCLES)
    + LTMC_HOLD_MARGIN;

  // ---------------------------------------------------------------
  // Host register map (byte addresses) and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] LTMC_OFS_CTRL = 8'h00;
  localparam logic [7:0] LTMC_OFS_TXBIT = 8'h04;
  localparam logic [7:0] LTMC_OFS_STATUS = 8'h08;
  localparam logic [7:0] LTMC_OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] LTMC_OFS_IRQ_CLR = 8'h10;
  localparam logic [7:0] LTMC_OFS_IRQ_EN = 8'h14;
  localparam int LTMC_CTRL_AWAKE = 0;
  localparam int LTMC_CTRL_TXEN = 1;
  localparam int LTMC_CTRL_SLP_FLOAT = 2;
  localparam int LTMC_IRQ_WAKE = 0;
  localparam int LTMC_IRQ_TXDONE = 1;
  localparam int LTMC_IRQ_W = 2;
  localparam logic [2:0] LTMC_CTRL_RESET = 3'h0;

  // ---------------------------------------------------------------
  // Operating modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    LTMC_POWER_ON,
    LTMC_SLEEP,
    LTMC_STANDBY,
    LTMC_NORMAL
  } ltmc_mode_t;

endpackage

// ### ltmc_if.sv
// Carrier between the controller end and the transceiver end.
// Resolves the open-drain receive line and the pulled-down control pins.
`timescale 1ns/1ps
interface ltmc_if;

  // ---------------------------------------------------------------
  // Pin drives
  // ---------------------------------------------------------------
  logic txd_o;
  logic txd_oe_n;
  logic slp_o;
  logic slp_oe_n;
  logic rxd_o;
  logic rxd_oe_n;
  logic txd_w;
  logic slp_w;
  logic rxd_w;

  // Undriven control pins settle low through their pull-downs.
  assign txd_w = txd_oe_n ? 1'b0 : txd_o;
  assign slp_w = slp_oe_n ? 1'b0 : slp_o;
  // The receive output is open drain, so a released line reads high.
  assign rxd_w = (!rxd_oe_n && !rxd_o) ? 1'b0 : 1'b1;

  modport dev (
    input txd_w,
    input slp_w,
    output rxd_o,
    output rxd_oe_n
  );

  modport host (
    output txd_o,
    output txd_oe_n,
    output slp_o,
    output slp_oe_n,
    input rxd_w
  );

endinterface // ltmc_if

// ### ltmc_dev.sv
// Transceiver end: mode sequencing, wake-up filters and bus driver gating.
// Assumes analog comparators deliver supply and temperature flags as levels
// and that the bus pin is resolved outside from the open-drain drive.
`timescale 1ns/1ps
module ltmc_dev
  import ltmc_pkg::*;
#(
  parameter logic [LTMC_CNT_W-1:0] NORM_CYCLES = LTMC_CNT_W'(LTMC_NORM_CYCLES),
  parameter logic [LTMC_CNT_W-1:0] SLEEP_CYCLES = LTMC_CNT_W'(LTMC_SLEEP_CYCLES),
  parameter logic [LTMC_CNT_W-1:0] WAKE_CYCLES = LTMC_CNT_W'(LTMC_WAKE_CYCLES)
)
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // Controller pins
  ltmc_if.dev LINK,
  // Supply and temperature indications
  input wire logic BAT_BELOW_LOW,
  input wire logic BAT_ABOVE_HIGH,
  input wire logic OVER_TEMP,
  // Bus line
  input wire logic LIN_IN,
  output logic LIN_OUT,
  output logic LIN_OE_N,
  // Status
  output ltmc_mode_t MODE,
  output logic WAKE_SOURCE
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    ltmc_mode_t mode;
    logic [1:0] txd_s;
    logic [1:0] slp_s;
    logic [1:0] lin_s;
    logic [1:0] low_s;
    logic [1:0] high_s;
    logic [1:0] hot_s;
    logic lin_prev;
    logic lin_armed;
    logic [LTMC_CNT_W-1:0] norm_cnt;
    logic [LTMC_CNT_W-1:0] sleep_cnt;
    logic [LTMC_CNT_W-1:0] wake_cnt;
    logic wake_req;
    logic wake_src;
    logic drv_armed;
    logic uv;
    logic rxd_oe_n;
    logic lin_oe_n;
    logic drive_lvl;
  } ltmc_dev_state_t;

  localparam ltmc_dev_state_t LTMC_DEV_RESET = '{
    mode: LTMC_POWER_ON,
    txd_s: 2'h0,
    slp_s: 2'h0,
    lin_s: 2'h0,
    low_s: 2'h0,
    high_s: 2'h0,
    hot_s: 2'h0,
    lin_prev: 1'b0,
    lin_armed: 1'b0,
    norm_cnt: '0,
    sleep_cnt: '0,
    wake_cnt: '0,
    wake_req: 1'b0,
    wake_src: 1'b0,
    drv_armed: 1'b0,
    uv: 1'b1,
    rxd_oe_n: 1'b1,
    lin_oe_n: 1'b1,
    drive_lvl: 1'b0
  };

  ltmc_dev_state_t q;
  ltmc_dev_state_t d;
  logic txd;
  logic slp;
  logic lin;
  logic bat_low;
  logic bat_high;
  logic hot;
  logic norm_ok;
  logic sleep_ok;
  logic wake_ok;
  logic drv_on;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------

  // All pins come from other domains, so only the second stage is read.
  always_comb
  begin
    d = q;
    d.txd_s = {q.txd_s[0], LINK.txd_w};
    d.slp_s = {q.slp_s[0], LINK.slp_w};
    d.lin_s = {q.lin_s[0], LIN_IN};
    d.low_s = {q.low_s[0], BAT_BELOW_LOW};
    d.high_s = {q.high_s[0], BAT_ABOVE_HIGH};
    d.hot_s = {q.hot_s[0], OVER_TEMP};
    txd = q.txd_s[1];
    slp = q.slp_s[1];
    lin = q.lin_s[1];
    bat_low = q.low_s[1];
    bat_high = q.high_s[1];
    hot = q.hot_s[1];
    d.lin_prev = lin;

    // Undervoltage latch with hysteresis between the two thresholds.
    if (bat_low)
    begin
      d.uv = 1'b1;
    end
    else if (bat_high)
    begin
      d.uv = 1'b0;
    end

    // Go-to-normal filter; any low cycle restarts it.
    if (slp && q.mode != LTMC_POWER_ON)
    begin
      if (q.norm_cnt != NORM_CYCLES)
      begin
        d.norm_cnt = q.norm_cnt + 1'b1;
      end
    end
    else
    begin
      d.norm_cnt = '0;
    end
    norm_ok = slp && (q.norm_cnt == NORM_CYCLES);

    // Go-to-sleep filter counts low cycles in normal mode only.
    if (!slp && q.mode == LTMC_NORMAL)
    begin
      if (q.sleep_cnt != SLEEP_CYCLES)
      begin
        d.sleep_cnt = q.sleep_cnt + 1'b1;
      end
    end
    else
    begin
      d.sleep_cnt = '0;
    end
    // True on the low cycle after the count is full: strictly longer.
    sleep_ok = !slp && (q.sleep_cnt == SLEEP_CYCLES);

    // Bus wake-up filter. Arming on a high level means a bus already low
    // at sleep entry cannot wake the device; a real falling edge is needed.
    if (q.mode == LTMC_SLEEP)
    begin
      if (lin)
      begin
        d.lin_armed = 1'b1;
        d.wake_cnt = '0;
      end
      else if (q.lin_armed && q.wake_cnt != WAKE_CYCLES)
      begin
        d.wake_cnt = q.wake_cnt + 1'b1;
      end
    end
    else
    begin
      d.lin_armed = 1'b0;
      d.wake_cnt = '0;
    end
    // Accepted only at the rising edge that ends a long enough low.
    wake_ok = (q.mode == LTMC_SLEEP) && lin && !q.lin_prev && q.lin_armed
      && (q.wake_cnt == WAKE_CYCLES);

    // A high sleep control level clears both flags at once.
    if (slp)
    begin
      d.wake_req = 1'b0;
      d.wake_src = 1'b0;
    end

    // Mode sequencing; a low supply overrides everything.
    if (bat_low)
    begin
      d.mode = LTMC_POWER_ON;
    end
    else
    begin
      unique case (q.mode)
        LTMC_POWER_ON:
        begin
          if (!q.uv)
          begin
            d.mode = LTMC_SLEEP;
          end
        end
        LTMC_SLEEP:
        begin
          if (norm_ok)
          begin
            d.mode = LTMC_NORMAL;
            d.drv_armed = 1'b0;
          end
          else if (wake_ok)
          begin
            d.mode = LTMC_STANDBY;
            d.wake_req = 1'b1;
            d.wake_src = 1'b1;
          end
        end
        LTMC_STANDBY:
        begin
          if (norm_ok)
          begin
            d.mode = LTMC_NORMAL;
            d.drv_armed = 1'b0;
          end
        end
        LTMC_NORMAL:
        begin
          if (sleep_ok)
          begin
            d.mode = LTMC_SLEEP;
          end
          else if (txd)
          begin
            d.drv_armed = 1'b1;
          end
        end
      endcase
    end

    // Bus driver: open drain, pulling low only for a dominant bit.
    drv_on = (d.mode == LTMC_NORMAL) && q.drv_armed && !hot && !d.uv;
    d.lin_oe_n = !(drv_on && !txd);

    // Receive output: bus data in normal, wake request in standby, else released.
    d.rxd_oe_n = !(((d.mode == LTMC_NORMAL) && !lin)
      || ((d.mode == LTMC_STANDBY) && d.wake_req));
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------

  // One register bank for the whole end.
  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      q <= LTMC_DEV_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs come straight from the state register.
  assign LINK.rxd_o = q.drive_lvl;
  assign LINK.rxd_oe_n = q.rxd_oe_n;
  assign LIN_OUT = q.drive_lvl;
  assign LIN_OE_N = q.lin_oe_n;
  assign MODE = q.mode;
  assign WAKE_SOURCE = q.wake_src;

endmodule // ltmc_dev

// ### ltmc_host.sv
// Controller end: drives transmit and sleep control pins, watches receive.
// Assumes a classic Wishbone master on the same clock as this end.
`timescale 1ns/1ps
module ltmc_host
  import ltmc_pkg::*;
#(
  parameter logic [LTMC_CNT_W-1:0] BIT_CYCLES = LTMC_CNT_W'(LTMC_BIT_CYCLES),
  parameter logic [LTMC_CNT_W-1:0] HOLD_CYCLES = LTMC_CNT_W'(LTMC_HOLD_CYCLES)
)
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Interrupt
  output logic IRQ,
  // Transceiver pins
  ltmc_if.host LINK
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] rxd_s;
    logic rxd_prev;
    logic [2:0] ctrl;
    logic slp;
    logic [LTMC_CNT_W-1:0] hold_cnt;
    logic tx_busy;
    logic tx_lvl;
    logic [LTMC_CNT_W-1:0] bit_cnt;
    logic txd;
    logic [LTMC_IRQ_W-1:0] irq_stat;
    logic [LTMC_IRQ_W-1:0] irq_en;
    logic irq;
    logic ack;
    logic [31:0] dat;
  } ltmc_host_state_t;

  ltmc_host_state_t q;
  ltmc_host_state_t d;
  logic rxd;
  logic wr;
  logic [LTMC_IRQ_W-1:0] ev;
  logic [LTMC_IRQ_W-1:0] clr;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.rxd_s = {q.rxd_s[0], LINK.rxd_w};
    rxd = q.rxd_s[1];
    d.rxd_prev = rxd;
    ev = '0;
    clr = '0;

    // Ack one cycle after the request; the write lands on the acked edge.
    wr = WB_CYC_I && WB_STB_I && WB_WE_I && q.ack && WB_SEL_I[0];
    d.ack = WB_CYC_I && WB_STB_I && !q.ack;
    d.dat = 32'h0000_0000;
    if (d.ack && !WB_WE_I)
    begin
      unique case (WB_ADR_I)
        LTMC_OFS_CTRL: d.dat = {29'h0, q.ctrl};
        LTMC_OFS_STATUS: d.dat = {28'h0, q.slp != q.ctrl[LTMC_CTRL_AWAKE], q.slp, q.tx_busy, rxd};
        LTMC_OFS_IRQ_STAT: d.dat = {30'h0, q.irq_stat};
        LTMC_OFS_IRQ_EN: d.dat = {30'h0, q.irq_en};
        default: d.dat = 32'h0000_0000;
      endcase
    end
    if (wr && WB_ADR_I == LTMC_OFS_CTRL)
    begin
      d.ctrl = WB_DAT_I[2:0];
    end
    if (wr && WB_ADR_I == LTMC_OFS_IRQ_EN)
    begin
      d.irq_en = WB_DAT_I[LTMC_IRQ_W-1:0];
    end
    if (wr && WB_ADR_I == LTMC_OFS_IRQ_CLR)
    begin
      clr = WB_DAT_I[LTMC_IRQ_W-1:0];
    end

    // Each sleep control level is held long enough for the far filters.
    if (q.hold_cnt != HOLD_CYCLES)
    begin
      d.hold_cnt = q.hold_cnt + 1'b1;
    end
    else if (q.slp != q.ctrl[LTMC_CTRL_AWAKE])
    begin
      d.slp = q.ctrl[LTMC_CTRL_AWAKE];
      d.hold_cnt = '0;
    end

    // One bit per write, each held a full bit time; busy writes are dropped.
    if (q.tx_busy)
    begin
      if (q.bit_cnt == BIT_CYCLES - 1'b1)
      begin
        d.tx_busy = 1'b0;
        ev[LTMC_IRQ_TXDONE] = 1'b1;
      end
      else
      begin
        d.bit_cnt = q.bit_cnt + 1'b1;
      end
    end
    else if (wr && WB_ADR_I == LTMC_OFS_TXBIT)
    begin
      d.tx_busy = 1'b1;
      d.tx_lvl = WB_DAT_I[0];
      d.bit_cnt = '0;
    end
    // Idle transmit level is recessive high so the driver can arm.
    d.txd = d.tx_busy ? d.tx_lvl : 1'b1;

    // Wake request shows as a receive falling edge while asleep.
    ev[LTMC_IRQ_WAKE] = !rxd && q.rxd_prev && !q.slp;
    // Set wins over a clear in the same cycle.
    d.irq_stat = (q.irq_stat & ~clr) | ev;
    d.irq = |(d.irq_stat & d.irq_en);
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      q <= '{rxd_s: 2'h3, rxd_prev: 1'b1, ctrl: LTMC_CTRL_RESET, slp: 1'b0,
             hold_cnt: '0, tx_busy: 1'b0, tx_lvl: 1'b1, bit_cnt: '0, txd: 1'b1,
             irq_stat: '0, irq_en: '0, irq: 1'b0, ack: 1'b0, dat: 32'h0000_0000};
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs straight from the state register.
  assign WB_DAT_O = q.dat;
  assign WB_ACK_O = q.ack;
  assign IRQ = q.irq;
  assign LINK.txd_o = q.txd;
  assign LINK.txd_oe_n = !q.ctrl[LTMC_CTRL_TXEN];
  assign LINK.slp_o = q.slp;
  assign LINK.slp_oe_n = q.ctrl[LTMC_CTRL_SLP_FLOAT];

endmodule // ltmc_host

// ### ltmc_chk.sv
// Assertions on the pins between the controller end and the transceiver end.
// Assumes one clock domain and the shortened filter counts of the bench.
`timescale 1ns/1ps
module ltmc_chk
  import ltmc_pkg::*;
#(
  parameter int NORM = 8,
  parameter int SLEEP = 8
)
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // Carrier pins
  input wire logic txd_w,
  input wire logic slp_w,
  input wire logic rxd_oe_n,
  // Transceiver side
  input wire logic LIN_IN,
  input wire logic LIN_OE_N,
  input wire logic OVER_TEMP,
  input wire logic BAT_BELOW_LOW,
  input wire ltmc_mode_t MODE,
  input wire logic WAKE_SOURCE
);
  // --------
  // Helper state
  // --------
  typedef struct packed
  {
    logic [7:0] hi;
    logic [7:0] lo;
    logic seen;
  } ltmc_chk_st_t;
  ltmc_chk_st_t st_q;
  ltmc_chk_st_t st_d;

  // Run lengths of the sleep control level; they saturate so long runs never wrap.
  always_comb
  begin
    st_d = st_q;
    st_d.hi = !slp_w ? 8'h00 : (st_q.hi == 8'hff) ? st_q.hi : st_q.hi + 8'h01;
    st_d.lo = slp_w ? 8'h00 : (st_q.lo == 8'hff) ? st_q.lo : st_q.lo + 8'h01;
    st_d.seen = (MODE == LTMC_NORMAL) && (st_q.seen || txd_w);
  end

  // Registers the helper state.
  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // --------
  // Properties
  // --------
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  property p_norm_in;
    (MODE == LTMC_NORMAL) && ($past(MODE) != LTMC_NORMAL) |-> st_q.hi >= NORM;
  endproperty
  a_norm_in: assert property (p_norm_in) else $error("normal entered too early");
  property p_sleep_in;
    (MODE == LTMC_SLEEP) && ($past(MODE) == LTMC_NORMAL) |-> st_q.lo >= SLEEP;
  endproperty
  a_sleep_in: assert property (p_sleep_in) else $error("sleep entered too early");
  property p_drv_idle;
    (MODE != LTMC_NORMAL) && ($past(MODE) != LTMC_NORMAL) |-> LIN_OE_N;
  endproperty
  a_drv_idle: assert property (p_drv_idle) else $error("driver on outside normal");
  property p_rx_float;
    (MODE inside {LTMC_POWER_ON, LTMC_SLEEP}) && $stable(MODE) |-> rxd_oe_n;
  endproperty
  a_rx_float: assert property (p_rx_float) else $error("receive driven while asleep");
  property p_wake;
    $rose(WAKE_SOURCE) |-> (MODE == LTMC_STANDBY) && !rxd_oe_n;
  endproperty
  a_wake: assert property (p_wake) else $error("wake without standby flag");
  property p_wake_clr;
    (MODE == LTMC_STANDBY) && $rose(slp_w) |-> ##[1:5] rxd_oe_n && !WAKE_SOURCE;
  endproperty
  a_wake_clr: assert property (p_wake_clr) else $error("wake request kept");
  property p_ot;
    OVER_TEMP && $past(OVER_TEMP, 3) |-> LIN_OE_N;
  endproperty
  a_ot: assert property (p_ot) else $error("driver on while hot");
  property p_uv;
    BAT_BELOW_LOW && $past(BAT_BELOW_LOW, 4) |-> LIN_OE_N && (MODE == LTMC_POWER_ON);
  endproperty
  a_uv: assert property (p_uv) else $error("driver on at low supply");
  property p_echo;
    (MODE == LTMC_NORMAL && $stable(LIN_IN))[*5] |-> rxd_oe_n == LIN_IN;
  endproperty
  a_echo: assert property (p_echo) else $error("receive does not follow bus");
  property p_txd_gate;
    !LIN_OE_N |-> st_q.seen;
  endproperty
  a_txd_gate: assert property (p_txd_gate) else $error("driver before txd high");
  c_wake: cover property ($rose(WAKE_SOURCE));
  c_norm: cover property ((MODE == LTMC_NORMAL) && ($past(MODE) == LTMC_STANDBY));
  c_sleep: cover property ((MODE == LTMC_SLEEP) && ($past(MODE) == LTMC_NORMAL));
endmodule // ltmc_chk

// ### tb_top.sv
// Bench joining both ends through the carrier and a pulled-up bus line.
// Assumes shortened filter, hold and bit counts so scenarios stay brief.
`timescale 1ns/1ps
module tb_top
  import ltmc_pkg::*;
;
  // --------
  // Signals
  // --------
  logic clk, rst_n, cyc, stb, we, ack, irq, bat_lo, bat_hi, ot;
  logic bus_drv, lin_w, lin_out, lin_oe_n, wake_src;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdo, rd;
  ltmc_mode_t mode;
  int failures, num_checks;
  ltmc_if link();

  // The bus has a pull-up; the transceiver or the bench may pull it low.
  assign lin_w = (!lin_oe_n && !lin_out) ? 1'b0 : bus_drv;

  ltmc_dev #(.NORM_CYCLES(16'h0008), .SLEEP_CYCLES(16'h0008), .WAKE_CYCLES(16'h000c))
    ltmc_dev_i (.SYS_CLK(clk), .RESET_N(rst_n), .LINK(link), .BAT_BELOW_LOW(bat_lo),
    .BAT_ABOVE_HIGH(bat_hi), .OVER_TEMP(ot), .LIN_IN(lin_w), .LIN_OUT(lin_out),
    .LIN_OE_N(lin_oe_n), .MODE(mode), .WAKE_SOURCE(wake_src));
  ltmc_host #(.BIT_CYCLES(16'h0010), .HOLD_CYCLES(16'h0014)) ltmc_host_i (.SYS_CLK(clk),
    .RESET_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdo), .WB_ACK_O(ack), .IRQ(irq), .LINK(link));
  // The checker's default counts match the shortened filters above.
  ltmc_chk ltmc_chk_i (.SYS_CLK(clk), .RESET_N(rst_n),
    .txd_w(link.txd_w), .slp_w(link.slp_w), .rxd_oe_n(link.rxd_oe_n), .LIN_IN(lin_w),
    .LIN_OE_N(lin_oe_n), .OVER_TEMP(ot), .BAT_BELOW_LOW(bat_lo), .MODE(mode),
    .WAKE_SOURCE(wake_src));

  // --------
  // Shared tasks
  // --------
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
    begin
      $display("Result: passed");
    end
    else
    begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // A wait that ran out ends the run at once, as nothing after it is meaningful.
  task automatic tmo(input int n);
    if (n >= 300)
    begin
      failures++;
      $display("mismatch at %0t: wait ran out", $time);
      close_out();
    end
  endtask

  // Classic single cycle; the request is held until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 300);
    tmo(n);
    rd = rdo;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_mode(input ltmc_mode_t m);
    int n;
    n = 0;
    while (mode !== m && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    tmo(n);
  endtask

  // --------
  // Scenarios
  // --------
  task automatic t_power();
    // A write without its low byte lane must leave the control register alone.
    sel <= 4'h0;
    wb(1'b1, LTMC_OFS_CTRL, 32'h0000_0007);
    sel <= 4'hf;
    wb(1'b1, 8'h20, 32'h0000_0007);
    wb(1'b0, 8'h20, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    wb(1'b0, LTMC_OFS_CTRL, 32'h0000_0000);
    chk(rd, 32'(LTMC_CTRL_RESET));
    chk(mode, LTMC_POWER_ON);
    chk(link.rxd_w, 1'b1);
    bat_hi <= 1'b1;
    wait_mode(LTMC_SLEEP);
    $display("power test done");
  endtask

  task automatic t_wake();
    wb(1'b1, LTMC_OFS_IRQ_EN, 32'h0000_0003);
    bus_drv <= 1'b0;
    repeat (10) @(posedge clk);
    bus_drv <= 1'b1;
    repeat (6) @(posedge clk);
    chk(mode, LTMC_SLEEP);
    bus_drv <= 1'b0;
    repeat (20) @(posedge clk);
    chk(mode, LTMC_SLEEP);
    bus_drv <= 1'b1;
    wait_mode(LTMC_STANDBY);
    @(posedge clk);
    chk(wake_src, 1'b1);
    chk(link.rxd_w, 1'b0);
    repeat (6) @(posedge clk);
    chk(irq, 1'b1);
    wb(1'b0, LTMC_OFS_IRQ_STAT, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    wb(1'b1, LTMC_OFS_IRQ_EN, 32'h0000_0000);
    chk(irq, 1'b0);
    wb(1'b1, LTMC_OFS_IRQ_CLR, 32'h0000_0001);
    wb(1'b0, LTMC_OFS_IRQ_STAT, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    wb(1'b1, LTMC_OFS_IRQ_EN, 32'h0000_0002);
    $display("wake test done");
  endtask

  task automatic t_normal();
    int n;
    wb(1'b1, LTMC_OFS_CTRL, 32'h0000_0003);
    for (n = 0; n < 300 && link.rxd_w !== 1'b1; n++) @(posedge clk);
    tmo(n);
    chk(mode, LTMC_STANDBY);
    chk(wake_src, 1'b0);
    wait_mode(LTMC_NORMAL);
    $display("normal test done");
  endtask

  task automatic t_data();
    wb(1'b1, LTMC_OFS_TXBIT, 32'h0000_0000);
    repeat (6) @(posedge clk);
    chk(lin_oe_n, 1'b0);
    chk(link.rxd_w, 1'b0);
    repeat (20) @(posedge clk);
    chk(link.rxd_w, 1'b1);
    chk(irq, 1'b1);
    wb(1'b1, LTMC_OFS_IRQ_CLR, 32'h0000_0002);
    chk(irq, 1'b0);
    bus_drv <= 1'b0;
    repeat (5) @(posedge clk);
    chk(link.rxd_w, 1'b0);
    bus_drv <= 1'b1;
    repeat (5) @(posedge clk);
    chk(link.rxd_w, 1'b1);
    // Floating the sleep control pin briefly gives a low pulse too short to sleep.
    wb(1'b1, LTMC_OFS_CTRL, 32'h0000_0007);
    wb(1'b1, LTMC_OFS_CTRL, 32'h0000_0003);
    repeat (20) @(posedge clk);
    chk(mode, LTMC_NORMAL);
    $display("data test done");
  endtask

  task automatic t_sleep();
    wb(1'b1, LTMC_OFS_CTRL, 32'h0000_0002);
    wait_mode(LTMC_SLEEP);
    chk(lin_oe_n, 1'b1);
    wb(1'b1, LTMC_OFS_CTRL, 32'h0000_0005);
    repeat (30) @(posedge clk);
    chk(link.slp_w, 1'b0);
    chk(link.txd_w, 1'b0);
    chk(mode, LTMC_SLEEP);
    // Released receive line, idle transmitter, host level high and settled.
    wb(1'b0, LTMC_OFS_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0005);
    $display("sleep test done");
  endtask

  task automatic t_fault();
    wb(1'b1, LTMC_OFS_CTRL, 32'h0000_0003);
    wait_mode(LTMC_NORMAL);
    ot <= 1'b1;
    wb(1'b1, LTMC_OFS_TXBIT, 32'h0000_0000);
    repeat (8) @(posedge clk);
    chk(lin_oe_n, 1'b1);
    ot <= 1'b0;
    repeat (20) @(posedge clk);
    bat_hi <= 1'b0;
    bat_lo <= 1'b1;
    wait_mode(LTMC_POWER_ON);
    bat_lo <= 1'b0;
    repeat (10) @(posedge clk);
    chk(mode, LTMC_POWER_ON);
    bat_hi <= 1'b1;
    wait_mode(LTMC_SLEEP);
    wait_mode(LTMC_NORMAL);
    wb(1'b1, LTMC_OFS_TXBIT, 32'h0000_0000);
    repeat (6) @(posedge clk);
    chk(lin_oe_n, 1'b0);
    $display("fault test done");
  endtask

  // Free-running system clock.
  initial
  begin
    clk = 1'b0;
    forever
    begin
      #2 clk = ~clk;
    end
  end

  // Main sequence.
  initial
  begin
    failures = 0;
    num_checks = 0;
    {rst_n, cyc, stb, we, bat_lo, bat_hi, ot} = 7'h00;
    bus_drv = 1'b1;
    adr = 8'h00;
    sel = 4'hf;
    wdat = 32'h0000_0000;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_power();
    t_wake();
    t_normal();
    t_data();
    t_sleep();
    t_fault();
    close_out();
  end
endmodule // tb_top
